// >>> hdl/cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_regs_map.svh"

module cfg_regs #(
    parameter logic [11:0] MAKER_CODE = 12'h5a5, // arbitrary value
    parameter logic [15:0] MODEL_SLOT0 = 16'h0101, // arbitrary value
    parameter logic [15:0] MODEL_OTHER = 16'h0202 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire cfg_regs_pkg::bus_req_s i_req,
    output cfg_regs_pkg::bus_rsp_s o_rsp,
    input wire logic [7:0] i_static_laddr,
    input wire logic i_slot0_pin,
    input wire logic i_select_pin,
    input wire logic i_selftest_done,
    input wire logic i_selftest_ok,
    input wire logic i_fail_req,
    output logic o_fail_out,
    output logic o_fail_oe,
    input wire logic [12:0] i_sel_lines,
    output logic [12:0] o_sel_out,
    output logic [12:0] o_sel_oe,
    output logic o_soft_rst
);
    import cfg_regs_pkg::*;

    logic slot0_s;
    logic select_s;
    logic [12:0] lines_s;
    logic hit;
    logic [5:0] ofs;
    logic [7:0] laddr_q, laddr_d;
    logic fail_inh_q, fail_inh_d;
    logic sel_oe_q, sel_oe_d;
    logic [12:0] sel_lvl_q, sel_lvl_d;
    logic strap_done_q, strap_done_d;
    soft_rst_e rst_st_q, rst_st_d;
    logic [3:0] rst_cnt_q, rst_cnt_d;
    bus_rsp_s rsp_q, rsp_d;
    logic fail_q, fail_d;
    logic [12:0] sel_out_q, sel_out_d;
    logic [12:0] sel_oe_out_q, sel_oe_out_d;
    logic wr, rd;
    logic [15:0] id_word;
    logic [15:0] stat_word;
    logic ready_now;
    logic soft_rst_q, soft_rst_d;
    logic fail_out_q, fail_out_d;

    // control write asking for a soft reset; shared by the sequencer and its check
    function automatic logic soft_rst_req(input logic w, input logic [5:0] o, input logic [15:0] d);
        return w && (o == `OFS_STAT_CTRL) && d[`CTRL_SOFT_RST_BIT];
    endfunction : soft_rst_req

    // pins come from the backplane, so they are synchronised
    sync2 #(.W(15)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_slot0_pin, i_select_pin, i_sel_lines}),
        .o_sync({slot0_s, select_s, lines_s})
    );

    // window decode follows the address register as soon as it changes
    addr_match u_match (
        .i_addr(i_req.addr),
        .i_laddr(laddr_q),
        .o_hit(hit),
        .o_ofs(ofs)
    );

    // readback words
    always_comb begin
        wr = i_req.strobe && i_req.write && hit && (rst_st_q == RST_IDLE);
        rd = i_req.strobe && !i_req.write && hit;
        ready_now = i_selftest_done && (rst_st_q == RST_IDLE);
        id_word = {`CLASS_REGISTER_BASED, `ADDR_SPACE_A16_ONLY, MAKER_CODE};
        stat_word = '0;
        stat_word[`STAT_NOT_SEL_BIT] = !select_s;
        stat_word[`STAT_SLOT0_BIT] = slot0_s;
        stat_word[`STAT_LADDR_LSB +: 8] = laddr_q;
        stat_word[`STAT_READY_BIT] = ready_now;
        stat_word[`STAT_PASSED_BIT] = ready_now && i_selftest_ok;
    end

    // register writes; a strap is caught one cycle after reset release
    always_comb begin
        laddr_d = laddr_q;
        fail_inh_d = fail_inh_q;
        sel_oe_d = sel_oe_q;
        sel_lvl_d = sel_lvl_q;
        strap_done_d = 1'b1;
        if (!strap_done_q) begin
            // 255 keeps the register at ff until the master assigns one
            laddr_d = i_static_laddr;
        end else if (wr) begin
            unique case (ofs)
                `OFS_ID_LADDR: laddr_d = i_req.wdata[7:0];
                `OFS_STAT_CTRL: fail_inh_d = i_req.wdata[`CTRL_FAIL_INH_BIT];
                `OFS_SELECT: begin
                    sel_oe_d = i_req.wdata[`SEL_OE_BIT];
                    if (sel_oe_q) begin
                        sel_lvl_d = i_req.wdata[`SEL_LINES-1:0];
                    end
                end
                default: ;
            endcase
        end
        // a running soft reset overrides whatever the bus asked for
        if (rst_st_q == RST_HOLD) begin
            fail_inh_d = `RST_FAIL_INH;
            sel_oe_d = `RST_SEL_OE;
        end
    end

    // soft reset sequencer; soft reset also clears driver enable
    always_comb begin
        rst_st_d = rst_st_q;
        rst_cnt_d = rst_cnt_q;
        unique case (rst_st_q)
            RST_IDLE: begin
                if (soft_rst_req(wr, ofs, i_req.wdata)) begin
                    rst_st_d = RST_HOLD;
                    rst_cnt_d = `SOFT_RST_CYCLES;
                end
            end
            RST_HOLD: begin
                rst_cnt_d = 4'(rst_cnt_q - 4'h1);
                if (rst_cnt_q == 4'h1) begin
                    rst_st_d = RST_IDLE;
                end
            end
        endcase
        // the pulse leaves from a flop so the port never glitches
        soft_rst_d = (rst_st_d == RST_HOLD);
    end

    // bus answer and pin drives, all registered
    always_comb begin
        rsp_d.ack = i_req.strobe && hit;
        rsp_d.rdata = '0;
        if (rd) begin
            unique case (ofs)
                `OFS_ID_LADDR: rsp_d.rdata = id_word;
                `OFS_MODEL: rsp_d.rdata = slot0_s ? MODEL_SLOT0 : MODEL_OTHER;
                `OFS_STAT_CTRL: rsp_d.rdata = stat_word;
                `OFS_SELECT: rsp_d.rdata = {2'b00, sel_oe_q, lines_s};
                default: rsp_d.rdata = '0;
            endcase
        end
        fail_d = i_fail_req && !fail_inh_q;
        sel_out_d = sel_lvl_q;
        sel_oe_out_d = {13{sel_oe_q}};
        fail_out_d = 1'b0; // open collector, so only low is ever driven
    end

    // register group; soft reset clears are already folded into the next values
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            laddr_q <= `RST_LADDR;
            fail_inh_q <= `RST_FAIL_INH;
            sel_oe_q <= `RST_SEL_OE;
            sel_lvl_q <= `RST_SEL_LEVEL;
            strap_done_q <= 1'b0;
        end else begin
            laddr_q <= laddr_d;
            fail_inh_q <= fail_inh_d;
            sel_oe_q <= sel_oe_d;
            sel_lvl_q <= sel_lvl_d;
            strap_done_q <= strap_done_d;
        end
    end

    // soft reset sequencer state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_st_q <= RST_IDLE;
            rst_cnt_q <= `RST_SOFT_CNT;
            soft_rst_q <= 1'b0;
        end else begin
            rst_st_q <= rst_st_d;
            rst_cnt_q <= rst_cnt_d;
            soft_rst_q <= soft_rst_d;
        end
    end

    // bus answer and pin drives
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rsp_q <= '0;
            fail_q <= 1'b0;
            fail_out_q <= 1'b0;
            sel_out_q <= '0;
            sel_oe_out_q <= '0;
        end else begin
            rsp_q <= rsp_d;
            fail_q <= fail_d;
            fail_out_q <= fail_out_d;
            sel_out_q <= sel_out_d;
            sel_oe_out_q <= sel_oe_out_d;
        end
    end

    // every output leaves straight from a flop
    assign o_fail_out = fail_out_q;
    assign o_fail_oe = fail_q;
    assign o_rsp = rsp_q;
    assign o_sel_out = sel_out_q;
    assign o_sel_oe = sel_oe_out_q;
    assign o_soft_rst = soft_rst_q;

    id_word_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_ID_LADDR) |=> (o_rsp.rdata == {4'hf, MAKER_CODE}))
        else $error("id word wrong");
    laddr_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr && strap_done_q && ofs == `OFS_ID_LADDR) |=> (laddr_q == $past(i_req.wdata[7:0])))
        else $error("address not loaded");
    strap_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !strap_done_q |=> (laddr_q == $past(i_static_laddr)))
        else $error("strap not preloaded");
    model_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_MODEL) |=> (o_rsp.rdata == ($past(slot0_s) ? MODEL_SLOT0 : MODEL_OTHER)))
        else $error("model code wrong");
    status_laddr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL) |=> (o_rsp.rdata[11:4] == $past(laddr_q)))
        else $error("status address wrong");
    passed_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL && !ready_now) |=> (o_rsp.rdata[3:2] == 2'b00))
        else $error("passed before ready");
    fail_inhibit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        fail_inh_q |=> !o_fail_oe)
        else $error("fail line driven while inhibited");
    soft_rst_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        soft_rst_req(wr, ofs, i_req.wdata) |=> o_soft_rst [*4] ##1 !o_soft_rst)
        else $error("soft reset length wrong");
    sel_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!sel_oe_q && strap_done_q) |=> (sel_lvl_q == $past(sel_lvl_q)))
        else $error("levels changed while disabled");
    unused_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && (ofs == 6'h06 || ofs > 6'h08)) |=> (o_rsp.rdata == 16'h0000))
        else $error("unused offset nonzero");

    // answer timing, status fields and control and pin effects, each one cycle after its cause
    miss_no_ack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_req.strobe && !hit) |=> !o_rsp.ack)
        else $error("ack given on a miss");
    hit_ack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_req.strobe && hit) |=> o_rsp.ack)
        else $error("no ack on a hit");
    not_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL) |=> (o_rsp.rdata[`STAT_NOT_SEL_BIT] == !$past(select_s)))
        else $error("select flag wrong");
    slot0_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL) |=> (o_rsp.rdata[`STAT_SLOT0_BIT] == $past(slot0_s)))
        else $error("slot flag wrong");
    ready_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL && !i_selftest_done) |=> !o_rsp.rdata[`STAT_READY_BIT])
        else $error("ready while self-test runs");
    status_unused_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rd && ofs == `OFS_STAT_CTRL) |=> (o_rsp.rdata[15] == 1'b0 && o_rsp.rdata[12] == 1'b0 && o_rsp.rdata[1:0] == 2'b00))
        else $error("unused status bits nonzero");
    read_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !rd |=> (o_rsp.rdata == 16'h0000))
        else $error("read data without a read");
    fail_drive_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_fail_req && !fail_inh_q) |=> o_fail_oe)
        else $error("fail line not driven");
    soft_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rst_st_q == RST_HOLD) |=> (!fail_inh_q && !sel_oe_q))
        else $error("soft reset left controls set");
    sel_enable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        sel_oe_q |=> (o_sel_oe == 13'h1fff))
        else $error("drivers not enabled");
    sel_drive_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        strap_done_q |=> (o_sel_out == $past(sel_lvl_q)))
        else $error("drive levels wrong");
    strap_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (strap_done_q && !wr) |=> (laddr_q == $past(laddr_q)))
        else $error("address changed without a write");
endmodule : cfg_regs
`default_nettype wire

// >>> hdl/cfg_regs_map.svh
`ifndef CFG_REGS_MAP_SVH
`define CFG_REGS_MAP_SVH

// window placement in a16 space
`define WIN_BASE 16'hc000
`define WIN_STRIDE_SHIFT 6
`define WIN_OFS_W 6
// register offsets inside the 64-byte window
`define OFS_ID_LADDR 6'h00
`define OFS_MODEL 6'h02
`define OFS_STAT_CTRL 6'h04
`define OFS_SELECT 6'h08
// identification word fields
`define CLASS_REGISTER_BASED 2'b11
`define ADDR_SPACE_A16_ONLY 2'b11
// dynamic configuration address
`define LADDR_DYNAMIC 8'hff
// status bit positions
`define STAT_NOT_SEL_BIT 14
`define STAT_SLOT0_BIT 13
`define STAT_LADDR_LSB 4
`define STAT_READY_BIT 3
`define STAT_PASSED_BIT 2
// control bit positions
`define CTRL_FAIL_INH_BIT 1
`define CTRL_SOFT_RST_BIT 0
// select-line register
`define SEL_OE_BIT 13
`define SEL_LINES 13
// reset values
`define RST_FAIL_INH 1'b0
`define RST_SEL_OE 1'b0
`define RST_SEL_LEVEL 13'h0000
`define RST_LADDR 8'h00
`define RST_SOFT_CNT 4'h0
// soft reset pulse length in cycles
`define SOFT_RST_CYCLES 4'h4

`endif

// >>> hdl/cfg_regs_pkg.sv
`default_nettype none
package cfg_regs_pkg;
    // one slave access from the bus front end
    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } bus_rsp_s;

    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_HOLD = 2'b01
    } soft_rst_e;
endpackage : cfg_regs_pkg
`default_nettype wire

// >>> hdl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin levels
module sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage only feeds second stage
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : sync2
`default_nettype wire

// >>> hdl/addr_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_regs_map.svh"
// decides whether an a16 address hits this module's window
module addr_match (
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_laddr,
    output logic o_hit,
    output logic [5:0] o_ofs
);
    logic [15:0] base;

    // base = c000 + laddr * 40
    always_comb begin
        base = 16'(`WIN_BASE + (16'(i_laddr) << `WIN_STRIDE_SHIFT));
        o_hit = (i_addr[15:`WIN_OFS_W] == base[15:`WIN_OFS_W]);
        o_ofs = i_addr[`WIN_OFS_W-1:0];
    end
endmodule : addr_match
`default_nettype wire

// >>> dv/vxi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master side: one-cycle strobe, answer taken at the following edge
module vxi_master_model (
    input wire logic i_clk,
    input wire cfg_regs_pkg::bus_rsp_s i_rsp,
    output var cfg_regs_pkg::bus_req_s o_req
);
    import cfg_regs_pkg::*;
    initial o_req = '0;
    // address and data flip when the strobe drops, so stale values never look valid
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ack);
        @(posedge i_clk);
        #1;
        o_req = '{strobe: 1'b1, write: wr, addr: a, wdata: wd};
        @(posedge i_clk);
        #1;
        ack = i_rsp.ack;
        rd = i_rsp.rdata;
        o_req = '{strobe: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
    endtask : xfer
endmodule : vxi_master_model
`default_nettype wire

// >>> dv/vxi_slave_config_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module vxi_slave_config_registers_test;
    import cfg_regs_pkg::*;
    localparam logic [11:0] MK = 12'h5a5; // arbitrary value
    localparam logic [15:0] M0 = 16'h0101; // arbitrary value
    localparam logic [15:0] M1 = 16'h0202; // arbitrary value
    logic clk = 0;
    logic rst = 1;
    logic [7:0] la = 8'h05;
    logic [7:0] cur = 8'h05;
    logic slot0 = 0, sel = 0, done = 0, ok = 0, freq = 0, fail_oe, fail_out, srst;
    logic [12:0] ext = 13'h1234, lines, sel_out, sel_oe;
    bus_req_s req;
    bus_rsp_s rsp;
    int n_errors = 0, compares = 0, cycles = 0;
    // select lines: driven level where enabled, foreign level elsewhere
    assign lines = (sel_oe & sel_out) | (~sel_oe & ext);
    always #5 clk = ~clk;
    cfg_regs #(.MAKER_CODE(MK), .MODEL_SLOT0(M0), .MODEL_OTHER(M1)) u_cfg_regs (
        .i_clk(clk), .i_sys_rst(rst), .i_req(req), .o_rsp(rsp), .i_static_laddr(la),
        .i_slot0_pin(slot0), .i_select_pin(sel), .i_selftest_done(done), .i_selftest_ok(ok),
        .i_fail_req(freq), .o_fail_out(fail_out), .o_fail_oe(fail_oe), .i_sel_lines(lines),
        .o_sel_out(sel_out), .o_sel_oe(sel_oe), .o_soft_rst(srst));
    vxi_master_model u_vxi_master_model (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    function automatic logic [15:0] base(input logic [7:0] l);
        return 16'hc000 + {2'h0, l, 6'h00};
    endfunction : base
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one access in the current window; v is write data or expected read data
    task automatic acc(input logic w, input logic [5:0] o, input logic [15:0] v);
        logic [15:0] d;
        logic k;
        u_vxi_master_model.xfer(w, base(cur) + {10'h0, o}, v, d, k);
        chk({15'h0, k}, 16'h1);
        if (!w)
            chk(d, v);
    endtask : acc
    task automatic miss(input logic [15:0] a);
        logic [15:0] d;
        logic k;
        u_vxi_master_model.xfer(1'b0, a, 16'h0, d, k);
        chk({15'h0, k}, 16'h0);
    endtask : miss
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic t_id;
        acc(0, 6'h00, {4'hf, MK});
        acc(1, 6'h06, 16'hffff);
        acc(0, 6'h06, 16'h0);
        acc(0, 6'h01, 16'h0);
        for (int i = 10; i < 64; i += 18)
            acc(0, i[5:0], 16'h0);
        miss(base(cur) + 16'h40);
        miss(16'h8000);
        $display("test id done");
    endtask : t_id
    task automatic t_status;
        slot0 = 1;
        cyc(3);
        acc(0, 6'h02, M0);
        acc(0, 6'h04, {4'h6, cur, 4'h0});
        slot0 = 0;
        sel = 1;
        done = 1;
        ok = 1;
        cyc(3);
        acc(0, 6'h02, M1);
        acc(0, 6'h04, {4'h0, cur, 4'hc});
        ok = 0;
        cyc(1);
        acc(0, 6'h04, {4'h0, cur, 4'h8});
        $display("test status done");
    endtask : t_status
    task automatic t_laddr;
        acc(1, 6'h00, 16'hff37);
        miss(base(cur));
        cur = 8'h37;
        acc(0, 6'h04, {4'h0, 8'h37, 4'h8});
        $display("test laddr done");
    endtask : t_laddr
    task automatic t_ctrl;
        logic [15:0] n;
        freq = 1;
        cyc(2);
        chk({15'h0, fail_oe}, 16'h1);
        chk({15'h0, fail_out}, 16'h0);
        acc(1, 6'h04, 16'h0002);
        cyc(1);
        chk({15'h0, fail_oe}, 16'h0);
        acc(1, 6'h04, 16'h0001);
        n = 0;
        // soft reset pulse length counted over a window wider than the pulse
        repeat (8) begin
            n += {15'h0, srst};
            cyc(1);
        end
        chk(n, 16'h4);
        chk({15'h0, fail_oe}, 16'h1);
        $display("test ctrl done");
    endtask : t_ctrl
    task automatic t_select;
        acc(0, 6'h08, {3'h0, 13'h1234});
        acc(1, 6'h08, 16'h0aaa);
        cyc(3);
        acc(0, 6'h08, {3'h0, 13'h1234});
        // enable and levels in one write: the levels must wait for the enable
        acc(1, 6'h08, 16'h2aaa);
        cyc(1);
        chk({3'h0, sel_oe}, 16'h1fff);
        chk({3'h0, sel_out}, 16'h0000);
        acc(1, 6'h08, 16'hf555);
        cyc(3);
        chk({3'h0, sel_out}, 16'h1555);
        acc(0, 6'h08, 16'h3555);
        $display("test select done");
    endtask : t_select
    task automatic t_dyn;
        la = 8'hff;
        rst = 1;
        cyc(2);
        rst = 0;
        cur = 8'hff;
        acc(0, 6'h00, {4'hf, MK});
        chk({15'h0, fail_oe}, 16'h1);
        acc(0, 6'h08, {3'h0, 13'h1234});
        acc(1, 6'h00, 16'h0012);
        cur = 8'h12;
        acc(0, 6'h04, {4'h0, 8'h12, 4'h8});
        $display("test dyn done");
    endtask : t_dyn
    task automatic give_verdict;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 0;
        t_id;
        t_status;
        t_laddr;
        t_ctrl;
        t_select;
        t_dyn;
        give_verdict;
    end
endmodule : vxi_slave_config_registers_test
`default_nettype wire
